// ### program_rom_vector_lookup.sv
// program counter, vectors, reset cause flags, shadow save and table read
//
// How it works
// - after every reset fetching begins at address zero, the reset vector.
// - reset cause shows in flags: power-on 1/0, watchdog 0/0, external 1/1.
// - any reset clears the program counter and returns all registers to default.
// - timeout and power-down flags are readable bits of the status register.
// - an interrupt pushes the program counter and jumps to address 0008.
// - save and restore copy work and status, leaving both reset flags alone.
// - the shadow holds one level only; a second save overwrites the first.
// - 0001-0007 and 0009-000F are plain program space; 0008 is the vector.
// - table address takes middle index bits 1:0 as bits 9:8, low index as 7:0.
// - a table read puts the low byte in work and high byte in table high.
// - stepping the low index from FF to 00 leaves the middle index untouched.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module program_rom_vector_lookup (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // reset controller
  input  wire rom_seq_pkg::reset_src_t       reset_src,
  // core sequencing
  input  wire logic                          fetch_step,
  input  wire logic                          int_req,
  output logic      [rom_seq_pkg::ROM_AW-1:0] fetch_addr,
  output logic      [rom_seq_pkg::ROM_DW-1:0] instr_word,
  // register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata
);
  import rom_seq_pkg::*;

  typedef struct packed {
    // program counter and the staged low byte of a software jump
    logic [ROM_AW-1:0] pc;
    logic [7:0]        pc_low_stage;
    // working register, arithmetic flags and reset cause flags
    logic [7:0]        work;
    logic [2:0]        arith;
    logic              timeout_n;
    logic              powerdown_n;
    logic              cause_taken;
    // table index pair and the high half of the fetched word
    logic [7:0]        index_mid;
    logic [7:0]        index_low;
    logic [7:0]        table_high;
    // one-level shadow for save and restore
    logic [7:0]        shadow_work;
    logic [2:0]        shadow_arith;
    // table fetch sequence and its latched address
    fetch_state_t      fetch;
    logic [ROM_AW-1:0] table_addr;
    // ROM load staging and the registered write copy
    logic [ROM_AW-1:0] load_addr;
    logic [7:0]        load_low;
    logic              load_we;
    logic [ROM_DW-1:0] load_word;
    logic [ROM_AW-1:0] load_wr_addr;
    // registered read data
    logic [7:0]        rdata;
  } seq_state_t;

  // the sequencer state outside the return stack and the memory array lives in one register
  seq_state_t        state_reg;
  seq_state_t        state_next;

  // memory and return stack side signals
  logic [ROM_DW-1:0] table_word;
  logic [ROM_AW-1:0] stack_top;
  logic [STACK_PW:0] stack_level;
  logic              push;
  logic              pop;
  logic              wr_hit_cmd;

  // register write decode, used for every writable offset
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] ofs);
    return wr && (addr == ofs);
  endfunction : wr_hit

  // status byte as software sees it
  function automatic logic [7:0] status_byte(input seq_state_t s);
    logic [7:0] b;
    b                 = 8'h00;
    b[ST_TIMEOUT_N]   = s.timeout_n;
    b[ST_POWERDOWN_N] = s.powerdown_n;
    b[ST_BUSY]        = (s.fetch != FETCH_IDLE);
    b[2:0]            = s.arith;
    return b;
  endfunction : status_byte

  // read multiplexer; unmapped offsets read as zero
  function automatic logic [7:0] read_mux(input seq_state_t       s,
                                          input logic [7:0]       addr,
                                          input logic [STACK_PW:0] lvl);
    logic [7:0] d;
    d = 8'h00;
    unique case (addr)
      OFS_WORK:       d = s.work;
      OFS_STATUS:     d = status_byte(s);
      OFS_INDEX_MID:  d = s.index_mid;
      OFS_INDEX_LOW:  d = s.index_low;
      OFS_TABLE_HIGH: d = s.table_high;
      OFS_PC_LOW:     d = s.pc[7:0];
      OFS_PC_HIGH:    d = {6'h00, s.pc[9:8]};
      OFS_LOAD_LOW:   d = s.load_addr[7:0];
      OFS_LOAD_HIGH:  d = {6'h00, s.load_addr[9:8]};
      OFS_DATA_LOW:   d = s.load_low;
      OFS_STACK:      d = {5'h00, lvl};
      default:        d = 8'h00;
    endcase
    return d;
  endfunction : read_mux

  // command register decode, shared by every command bit
  assign wr_hit_cmd = wr_hit(reg_wr, reg_addr, OFS_COMMAND);

  // interrupt entry beats a return request issued in the same cycle
  assign push = int_req;
  assign pop  = !int_req && wr_hit_cmd && reg_wdata[CMD_INT_RETURN];

  // next state of the whole sequencer
  always_comb begin
    // hold by default; the load strobe and read data fall back to zero
    state_next         = state_reg;
    state_next.load_we = 1'b0;
    state_next.rdata   = 8'h00;

    // reset cause is caught on the first edge after release, never under reset
    if (!state_reg.cause_taken) begin
      state_next.cause_taken = 1'b1;
      unique case (reset_src)
        SRC_POWER_ON: begin
          state_next.timeout_n   = 1'b1;
          state_next.powerdown_n = 1'b0;
        end
        SRC_WATCHDOG: begin
          state_next.timeout_n   = 1'b0;
          state_next.powerdown_n = 1'b0;
        end
        SRC_EXTERNAL: begin
          state_next.timeout_n   = 1'b1;
          state_next.powerdown_n = 1'b1;
        end
        default: begin
          // an unused cause code reads like power-on
          state_next.timeout_n   = TIMEOUT_N_RST;
          state_next.powerdown_n = POWERDOWN_N_RST;
        end
      endcase
    end

    // program counter: interrupt, return, software jump, then plain step
    if (int_req) begin
      state_next.pc = INT_VECTOR;
    end else if (pop) begin
      state_next.pc = stack_top;
    end else if (wr_hit(reg_wr, reg_addr, OFS_PC_HIGH)) begin
      state_next.pc = {reg_wdata[1:0], state_reg.pc_low_stage};
    end else if (fetch_step) begin
      // the counter runs through 0001-000F like any other word
      state_next.pc = state_reg.pc + 10'h001;
    end
    // the low byte waits until the high byte write completes the jump
    if (wr_hit(reg_wr, reg_addr, OFS_PC_LOW)) begin
      state_next.pc_low_stage = reg_wdata;
    end

    // plain register writes
    if (wr_hit(reg_wr, reg_addr, OFS_WORK)) begin
      state_next.work = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, OFS_STATUS)) begin
      // reset flags are read only, only the arithmetic flags take the write
      state_next.arith = reg_wdata[2:0] & ST_ARITH_MASK;
    end
    if (wr_hit(reg_wr, reg_addr, OFS_INDEX_MID)) begin
      state_next.index_mid = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, OFS_INDEX_LOW)) begin
      state_next.index_low = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, OFS_TABLE_HIGH)) begin
      state_next.table_high = reg_wdata;
    end

    // stepping the low index never carries into the middle index
    if (wr_hit_cmd && reg_wdata[CMD_STEP_LOW]) begin
      state_next.index_low = state_reg.index_low + 8'h01;
    end

    // save into the one-level shadow; a later save simply replaces it
    // a restore in the same write as a save is dropped, saving is the safer pick
    if (wr_hit_cmd && reg_wdata[CMD_SAVE]) begin
      state_next.shadow_work  = state_reg.work;
      state_next.shadow_arith = state_reg.arith;
    end else if (wr_hit_cmd && reg_wdata[CMD_RESTORE]) begin
      // timeout and power-down flags are outside the shadow and stay put
      state_next.work  = state_reg.shadow_work;
      state_next.arith = state_reg.shadow_arith;
    end

    // table read: issue the address, then capture the registered word
    // a fetch command while busy falls outside the idle arm and is ignored
    unique case (state_reg.fetch)
      FETCH_IDLE: begin
        if (wr_hit_cmd && reg_wdata[CMD_ROM_FETCH]) begin
          // only ten address bits exist, so higher middle bits wrap
          state_next.table_addr = {state_reg.index_mid[1:0],
                                   state_reg.index_low};
          state_next.fetch      = FETCH_ISSUE;
        end
      end
      FETCH_ISSUE: begin
        // the ROM registers the table word at the end of this cycle
        state_next.fetch = FETCH_CAPTURE;
      end
      FETCH_CAPTURE: begin
        // completion wins over a software write in the same cycle
        state_next.work       = table_word[7:0];
        state_next.table_high = table_word[15:8];
        state_next.fetch      = FETCH_IDLE;
      end
    endcase

    // ROM load: low data byte is staged, the high byte commits the word
    if (wr_hit(reg_wr, reg_addr, OFS_LOAD_LOW)) begin
      state_next.load_addr[7:0] = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, OFS_LOAD_HIGH)) begin
      state_next.load_addr[9:8] = reg_wdata[1:0];
    end
    if (wr_hit(reg_wr, reg_addr, OFS_DATA_LOW)) begin
      state_next.load_low = reg_wdata;
    end
    // the word is written one cycle later from registered copies
    if (wr_hit(reg_wr, reg_addr, OFS_DATA_HIGH)) begin
      state_next.load_we      = 1'b1;
      state_next.load_word    = {reg_wdata, state_reg.load_low};
      state_next.load_wr_addr = state_reg.load_addr;
      // auto increment lets a loader stream words; it wraps at the top
      state_next.load_addr    = state_reg.load_addr + 10'h001;
    end

    // read data stands only in the cycle after the strobe
    if (reg_rd) begin
      state_next.rdata = read_mux(state_reg, reg_addr, stack_level);
    end
  end

  // every reset source lands here: counter to the reset vector, defaults back
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // shadow, table high, load staging and read data clear through the fill
      state_reg              <= '0;
      state_reg.pc           <= RESET_VECTOR;
      state_reg.work         <= WORK_RST;
      state_reg.arith        <= ARITH_RST;
      state_reg.index_mid    <= INDEX_RST;
      state_reg.index_low    <= INDEX_RST;
      state_reg.timeout_n    <= TIMEOUT_N_RST;
      state_reg.powerdown_n  <= POWERDOWN_N_RST;
      state_reg.fetch        <= FETCH_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // program memory; the fetch port follows the next counter value so the
  // instruction word lines up with fetch_addr in the same cycle
  // the table port reads from a registered address, a cycle behind the command
  rom_array u_rom (
    .mclk    (mclk),
    .wr_en   (state_reg.load_we),
    .wr_addr (state_reg.load_wr_addr),
    .wr_data (state_reg.load_word),
    .a_addr  (state_next.pc),
    .a_data  (instr_word),
    .b_addr  (state_reg.table_addr),
    .b_data  (table_word)
  );

  // return addresses for interrupt entry
  // the pushed value is the counter of the interrupted instruction
  return_stack u_stack (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .push      (push),
    .pop       (pop),
    .push_data (state_reg.pc),
    .top_data  (stack_top),
    .level     (stack_level)
  );

  // outputs straight from the state flops
  assign fetch_addr = state_reg.pc;
  assign reg_rdata  = state_reg.rdata;

endmodule : program_rom_vector_lookup

// ### rom_seq_pkg.sv
// constants, register map and types shared by the program memory sequencer
package rom_seq_pkg;

  // program memory geometry
  localparam int          ROM_WORDS      = 1024;
  localparam int          ROM_AW         = 10;
  localparam int          ROM_DW         = 16;
  localparam int          STACK_DEPTH    = 4;
  localparam int          STACK_PW       = 2;

  // fixed program addresses
  localparam logic [9:0]  RESET_VECTOR   = 10'h000;
  localparam logic [9:0]  INT_VECTOR     = 10'h008;
  localparam logic [9:0]  USER_START     = 10'h010;
  localparam logic [9:0]  USER_LAST      = 10'h3FC;
  localparam logic [9:0]  RESERVED_FIRST = 10'h3FD;
  localparam logic [9:0]  RESERVED_LAST  = 10'h3FF;

  // register offsets on the plain register port
  localparam logic [7:0]  OFS_WORK       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h01;
  localparam logic [7:0]  OFS_INDEX_MID  = 8'h02;
  localparam logic [7:0]  OFS_INDEX_LOW  = 8'h03;
  localparam logic [7:0]  OFS_TABLE_HIGH = 8'h04;
  localparam logic [7:0]  OFS_COMMAND    = 8'h05;
  localparam logic [7:0]  OFS_PC_LOW     = 8'h06;
  localparam logic [7:0]  OFS_PC_HIGH    = 8'h07;
  localparam logic [7:0]  OFS_LOAD_LOW   = 8'h08;
  localparam logic [7:0]  OFS_LOAD_HIGH  = 8'h09;
  localparam logic [7:0]  OFS_DATA_LOW   = 8'h0A;
  localparam logic [7:0]  OFS_DATA_HIGH  = 8'h0B;
  localparam logic [7:0]  OFS_STACK      = 8'h0C;

  // status register fields
  localparam int          ST_TIMEOUT_N   = 7;
  localparam int          ST_POWERDOWN_N = 6;
  localparam int          ST_BUSY        = 5;
  localparam logic [2:0]  ST_ARITH_MASK  = 3'h7;

  // command register bits, each one a self-clearing request
  localparam int          CMD_ROM_FETCH  = 0;
  localparam int          CMD_SAVE       = 1;
  localparam int          CMD_RESTORE    = 2;
  localparam int          CMD_STEP_LOW   = 3;
  localparam int          CMD_INT_RETURN = 4;

  // reset values
  localparam logic [7:0]  WORK_RST       = 8'h00;
  localparam logic [7:0]  INDEX_RST      = 8'h00;
  localparam logic [2:0]  ARITH_RST      = 3'h0;
  localparam logic        TIMEOUT_N_RST  = 1'b1;
  localparam logic        POWERDOWN_N_RST = 1'b0;

  // cause of the last restart, presented by the reset controller
  typedef enum logic [1:0] {
    SRC_POWER_ON,
    SRC_WATCHDOG,
    SRC_EXTERNAL
  } reset_src_t;

  // table fetch sequence
  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_ISSUE,
    FETCH_CAPTURE
  } fetch_state_t;

endpackage : rom_seq_pkg

// ### rom_array.sv
// 1K x 16 program memory with a load port and two registered read ports
`timescale 1ns/1ps
module rom_array (
  // clock
  input  wire logic                          mclk,
  // load port
  input  wire logic                          wr_en,
  input  wire logic [rom_seq_pkg::ROM_AW-1:0] wr_addr,
  input  wire logic [rom_seq_pkg::ROM_DW-1:0] wr_data,
  // instruction fetch port
  input  wire logic [rom_seq_pkg::ROM_AW-1:0] a_addr,
  output logic      [rom_seq_pkg::ROM_DW-1:0] a_data,
  // table read port
  input  wire logic [rom_seq_pkg::ROM_AW-1:0] b_addr,
  output logic      [rom_seq_pkg::ROM_DW-1:0] b_data
);
  import rom_seq_pkg::*;

  logic [ROM_DW-1:0] mem [ROM_WORDS];

  // no reset on the array so it maps onto block memory
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    a_data <= mem[a_addr];
    b_data <= mem[b_addr];
  end

endmodule : rom_array

// ### return_stack.sv
// four level hardware return stack for interrupt entry and return
`timescale 1ns/1ps
module return_stack (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // push and pop
  input  wire logic                          push,
  input  wire logic                          pop,
  input  wire logic [rom_seq_pkg::ROM_AW-1:0] push_data,
  output logic      [rom_seq_pkg::ROM_AW-1:0] top_data,
  output logic      [rom_seq_pkg::STACK_PW:0] level
);
  import rom_seq_pkg::*;

  typedef struct packed {
    logic [STACK_DEPTH-1:0][ROM_AW-1:0] entry;
    logic [STACK_PW-1:0]                ptr;
    logic [STACK_PW:0]                  used;
  } stack_state_t;

  stack_state_t state_reg;
  stack_state_t state_next;

  // a fifth push overwrites the oldest entry, as a wrapping ring
  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.entry[state_reg.ptr] = push_data;
      state_next.ptr                  = state_reg.ptr + 2'h1;
      if (state_reg.used != 3'(STACK_DEPTH)) begin
        state_next.used = state_reg.used + 3'h1;
      end
    end else if (pop) begin
      state_next.ptr = state_reg.ptr - 2'h1;
      if (state_reg.used != 3'h0) begin
        state_next.used = state_reg.used - 3'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign top_data = state_reg.entry[state_reg.ptr - 2'h1];
  assign level    = state_reg.used;

endmodule : return_stack

// ### program_rom_vector_lookup_checker.sv
// port assertions for the program memory sequencer
`timescale 1ns/1ps
module program_rom_vector_lookup_checker (
  // clock and reset
  input wire logic                            mclk,
  input wire logic                            rst_b,
  input wire rom_seq_pkg::reset_src_t         reset_src,
  // core side
  input wire logic                            fetch_step,
  input wire logic                            int_req,
  input wire logic [rom_seq_pkg::ROM_AW-1:0]  fetch_addr,
  input wire logic [rom_seq_pkg::ROM_DW-1:0]  instr_word,
  // register port
  input wire logic [7:0]                      reg_addr,
  input wire logic [7:0]                      reg_wdata,
  input wire logic                            reg_wr,
  input wire logic                            reg_rd,
  input wire logic [7:0]                      reg_rdata
);
  import rom_seq_pkg::*;
  logic       live_reg;
  logic [1:0] flags_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // flags are judged only once the capture edge after release has passed
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      live_reg  <= 1'b0;
      flags_reg <= 2'h2;
    end else if (!live_reg) begin
      live_reg  <= 1'b1;
      flags_reg <= (reset_src == SRC_WATCHDOG) ? 2'h0 :
                   (reset_src == SRC_EXTERNAL) ? 2'h3 : 2'h2;
    end
  end

  chk_reset_vector: assert property ($rose(rst_b) |-> fetch_addr == RESET_VECTOR)
    else $error("pc not at reset vector after release");
  chk_int_vector: assert property (int_req |=> fetch_addr == INT_VECTOR)
    else $error("interrupt did not enter the vector");
  chk_step_incr: assert property (fetch_step && !int_req && !reg_wr |=>
    fetch_addr == $past(fetch_addr) + 10'h001)
    else $error("pc did not advance by one");
  chk_pc_hold: assert property (!fetch_step && !int_req && !reg_wr |=> $stable(fetch_addr))
    else $error("pc moved without a cause");
  chk_flag_code: assert property (live_reg && reg_rd && reg_addr == OFS_STATUS |=>
    reg_rdata[7:6] == flags_reg)
    else $error("reset cause flags wrong");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_cmd_readzero: assert property (reg_rd && reg_addr == OFS_COMMAND |=> reg_rdata == 8'h00)
    else $error("command register read not zero");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > OFS_STACK |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_stack_bound: assert property (reg_rd && reg_addr == OFS_STACK |=> reg_rdata <= 8'h04)
    else $error("stack level above four");
endmodule : program_rom_vector_lookup_checker

bind program_rom_vector_lookup program_rom_vector_lookup_checker i_chk (
  .mclk(mclk), .rst_b(rst_b), .reset_src(reset_src), .fetch_step(fetch_step),
  .int_req(int_req), .fetch_addr(fetch_addr), .instr_word(instr_word), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// ### program_rom_vector_lookup_tb.sv
// self-checking bench for the program memory sequencer
`timescale 1ns/1ps
module program_rom_vector_lookup_tb;
  import rom_seq_pkg::*;
  logic              mclk;
  logic              rst_b;
  reset_src_t        reset_src;
  logic              fetch_step;
  logic              int_req;
  logic [ROM_AW-1:0] fetch_addr;
  logic [ROM_DW-1:0] instr_word;
  logic [7:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_rdata;
  int                n_fail;
  int                samples_checked;
  int                seed;
  int                k;
  logic [15:0]       rom_img [0:ROM_WORDS-1];
  logic [9:0]        ta;
  logic [7:0]        v;
  logic [7:0]        b;

  program_rom_vector_lookup i_program_rom_vector_lookup (
    .mclk(mclk), .rst_b(rst_b), .reset_src(reset_src), .fetch_step(fetch_step),
    .int_req(int_req), .fetch_addr(fetch_addr), .instr_word(instr_word),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // 50 MHz core clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  // bus tasks start just after an edge; the idle cycle keeps strobes single-driven
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask : rd

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask : rd_chk

  task automatic load_word(input logic [9:0] a, input logic [15:0] d);
    wr(OFS_LOAD_LOW, a[7:0]);
    wr(OFS_LOAD_HIGH, {6'h00, a[9:8]});
    wr(OFS_DATA_LOW, d[7:0]);
    wr(OFS_DATA_HIGH, d[15:8]);
    rom_img[a] = d;
  endtask : load_word

  // flags as {timeout_n, powerdown_n}; an unknown cause reads as power-on
  function automatic logic [1:0] exp_flags(input reset_src_t s);
    case (s)
      SRC_WATCHDOG: return 2'h0;
      SRC_EXTERNAL: return 2'h3;
      default:      return 2'h2;
    endcase
  endfunction : exp_flags

  task automatic apply_reset(input reset_src_t s);
    rst_b     <= 1'b0;
    reset_src <= s;
    repeat (5) @(posedge mclk);
    rst_b     <= 1'b1;
    @(posedge mclk);
  endtask : apply_reset

  task automatic step_chk(input logic [9:0] exp);
    fetch_step <= 1'b1;
    @(posedge mclk);
    fetch_step <= 1'b0;
    #1;
    chk("fetch_addr", {6'h00, exp}, {6'h00, fetch_addr});
    chk("instr_word", rom_img[exp], instr_word);
    @(posedge mclk);
  endtask : step_chk

  task automatic pulse_irq();
    int_req <= 1'b1;
    @(posedge mclk);
    int_req <= 1'b0;
    #1;
    chk("int fetch_addr", {6'h00, INT_VECTOR}, {6'h00, fetch_addr});
    chk("int instr_word", rom_img[INT_VECTOR], instr_word);
    @(posedge mclk);
  endtask : pulse_irq

  // a busy flag that never drops ends the run
  task automatic wait_idle();
    logic [7:0] d;
    int         n;
    n = 0;
    d = 8'hFF;
    while (d[ST_BUSY] !== 1'b0) begin
      rd(OFS_STATUS, d);
      n++;
      if (n > 20) begin
        $display("ERROR busy expected 0 seen %b", d[ST_BUSY]);
        n_fail++;
        end_sim();
      end
    end
  endtask : wait_idle

  initial begin
    seed = 33826;
    n_fail = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    reset_src = SRC_POWER_ON;
    fetch_step = 1'b0;
    int_req = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    apply_reset(SRC_POWER_ON);
    // image over the vectors, user start, a page crossing and the last user word
    for (k = 0; k < 17; k++) load_word(10'(k), 16'($random(seed)));
    load_word(10'h0FF, 16'($random(seed)));
    load_word(10'h100, 16'($random(seed)));
    load_word(USER_LAST, 16'($random(seed)));
    // each reset cause, entered from a disturbed state
    for (k = 0; k < 4; k++) begin
      wr(OFS_WORK, 8'hA5);
      wr(OFS_INDEX_LOW, 8'h3C);
      wr(OFS_STATUS, 8'h07);
      pulse_irq();
      apply_reset(reset_src_t'(2'(k)));
      #1;
      chk("reset pc", {6'h00, RESET_VECTOR}, {6'h00, fetch_addr});
      chk("reset word", rom_img[0], instr_word);
      @(posedge mclk);
      rd(OFS_STATUS, v);
      chk("flags", 16'(exp_flags(reset_src_t'(2'(k)))), 16'(v[7:6]));
      chk("arith", 16'(ARITH_RST), 16'(v[2:0]));
      rd_chk("work", OFS_WORK, WORK_RST);
      rd_chk("index_low", OFS_INDEX_LOW, INDEX_RST);
      rd_chk("stack level", OFS_STACK, 8'h00);
    end
    // straight fetch through the vector area into user code, then an interrupt
    for (k = 1; k <= 16; k++) step_chk(10'(k));
    pulse_irq();
    rd_chk("stack level", OFS_STACK, 8'h01);
    wr(OFS_COMMAND, 8'h10);
    #1;
    chk("return pc", {6'h00, USER_START}, {6'h00, fetch_addr});
    @(posedge mclk);
    // software jump to the last user word through the staged low byte
    wr(OFS_PC_LOW, USER_LAST[7:0]);
    wr(OFS_PC_HIGH, {6'h00, USER_LAST[9:8]});
    #1;
    chk("jump pc", {6'h00, USER_LAST}, {6'h00, fetch_addr});
    chk("jump word", rom_img[USER_LAST], instr_word);
    @(posedge mclk);
    rd_chk("pc low", OFS_PC_LOW, USER_LAST[7:0]);
    rd_chk("pc high", OFS_PC_HIGH, {6'h00, USER_LAST[9:8]});
    // table reads with junk above address bit 9 in the middle index
    for (k = 0; k < 10; k++) begin
      ta = (k == 0) ? 10'h0FF : (k == 1) ? 10'h100 : (k == 2) ? USER_LAST :
           {6'h00, 4'($random(seed))};
      v = 8'($random(seed));
      wr(OFS_INDEX_MID, {v[7:2], ta[9:8]});
      wr(OFS_INDEX_LOW, ta[7:0]);
      wr(OFS_COMMAND, 8'h01);
      wait_idle();
      rd_chk("table low", OFS_WORK, rom_img[ta][7:0]);
      rd_chk("table high", OFS_TABLE_HIGH, rom_img[ta][15:8]);
    end
    // low index wraps with no carry into the middle index
    wr(OFS_INDEX_MID, 8'h37);
    wr(OFS_INDEX_LOW, 8'hFF);
    wr(OFS_COMMAND, 8'h08);
    rd_chk("index_low", OFS_INDEX_LOW, 8'h00);
    rd_chk("index_mid", OFS_INDEX_MID, 8'h37);
    // two saves before one restore: the second one wins
    b = 8'($random(seed));
    wr(OFS_WORK, 8'($random(seed)));
    wr(OFS_STATUS, 8'hC5);
    wr(OFS_COMMAND, 8'h02);
    wr(OFS_WORK, b);
    wr(OFS_STATUS, 8'h02);
    wr(OFS_COMMAND, 8'h02);
    wr(OFS_WORK, ~b);
    wr(OFS_STATUS, 8'h06);
    wr(OFS_COMMAND, 8'h04);
    rd_chk("restored work", OFS_WORK, b);
    rd(OFS_STATUS, v);
    chk("restored arith", 16'h0002, 16'(v[2:0]));
    chk("kept flags", 16'(exp_flags(reset_src)), 16'(v[7:6]));
    rd_chk("command read", OFS_COMMAND, 8'h00);
    rd_chk("unmapped read", 8'h3D, 8'h00);
    end_sim();
  end

  // cuts a hung run short
  initial begin
    repeat (50000) @(posedge mclk);
    $display("ERROR run limit expected end seen timeout");
    n_fail++;
    end_sim();
  end
endmodule : program_rom_vector_lookup_tb
